//--- logic/psmc_pkg.sv
// Function
// RULE1 - reset ends in run mode at master clock
// RULE2 - modes entered by control bits or instructions
// RULE3 - slow mode divides master clock by 2/4/8/16
// RULE4 - wait during slow keeps reduced peripheral clock
// RULE5 - wait instruction stops only the cpu
// RULE6 - wait entry forces interrupt level to 10
// RULE7 - wait ends on interrupt, loads service vector
// RULE8 - push condition codes, set routine priority level
// RULE9 - plain halt when both enables cleared
// RULE10 - halt exit restarts oscillator, waits 256/4096
// RULE11 - halt entry forces interrupt level to 10
// RULE12 - halt stops oscillator and all internal clocks
// RULE13 - watchdog option decides reset or halt
// RULE14 - oscillator interrupt enable selects active halt
// RULE15 - auto wakeup enable selects rc-clocked halt
// RULE16 - stabilisation counter length sampled at reset
package psmc_pkg;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam int          CTRL_SLOW_BIT  = 0;
  localparam int          CTRL_DIV_LSB   = 1;
  localparam int          CTRL_OIE_BIT   = 3;
  localparam int          CTRL_AWU_BIT   = 4;
  localparam logic [4:0]  CTRL_RESET     = 5'h00;
  localparam int          STAT_SLOW_BIT  = 6;
  localparam int          STAT_BUSY_BIT  = 7;
  localparam int          STAT_OPT_BIT   = 8;
  localparam int          STAT_LVL_LSB   = 9;
  localparam logic [1:0]  CC_LVL_RESET   = 2'h3;
  localparam logic [1:0]  CC_LVL_FORCE   = 2'h2;
  localparam logic [15:0] VEC_RESET      = 16'hFFFE;
  localparam int          STAB_SHORT     = 256;
  localparam int          STAB_LONG      = 4096;
  localparam int          STAB_W         = 13;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

  typedef enum logic [5:0] {
    ST_RUN  = 6'h01,
    ST_WAIT = 6'h02,
    ST_HALT = 6'h04,
    ST_ACT  = 6'h08,
    ST_AWU  = 6'h10,
    ST_STAB = 6'h20
  } psmc_state_t;
endpackage

//--- logic/psmc_divider.sv
`timescale 1ns/1ns
`default_nettype none
module psmc_divider
  import psmc_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // selection
  input  wire logic       slow_mode_select,
  input  wire logic [1:0] slow_divider_select,
  // reduced clock pulse
  output logic            tick_q
);
  logic [3:0] cnt_q;
  logic [3:0] mask;

  // mask of 1, 3, 7 or 15 gives division by 2, 4, 8 or 16
  assign mask = 4'((5'h2 << slow_divider_select) - 5'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_q <= 1'b1;
    end else begin
      tick_q <= !slow_mode_select || ((cnt_q & mask) == mask); // [RULE3]
    end
  end
endmodule
`default_nettype wire

//--- logic/psmc_stab.sv
`timescale 1ns/1ns
`default_nettype none
module psmc_stab
  import psmc_pkg::*;
#(
  parameter int STAB_SHORT_CYC = STAB_SHORT,
  parameter int STAB_LONG_CYC  = STAB_LONG
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // control
  input  wire logic              start,
  input  wire logic              long_sel,
  // status
  output logic                   busy_q,
  output logic                   done_q,
  output logic [STAB_W-1:0]      term
);
  logic [STAB_W-1:0] cnt_q;

  assign term = long_sel ? STAB_W'(STAB_LONG_CYC) : STAB_W'(STAB_SHORT_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= term - STAB_W'(1); // [RULE16]
        busy_q <= 1'b1;
      end else if (busy_q && cnt_q == '0) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - STAB_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/psmc_top.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module psmc_top
  import psmc_pkg::*;
#(
  parameter int STAB_SHORT_CYC = STAB_SHORT,
  parameter int STAB_LONG_CYC  = STAB_LONG
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // cpu side
  input  wire logic        wait_for_interrupt_instr,
  input  wire logic        halt_instr,
  input  wire logic        irq_pending,
  input  wire logic        irq_halt_capable,
  input  wire logic [1:0]  irq_priority,
  input  wire logic [15:0] irq_vector,
  input  wire logic        cc_pop,
  input  wire logic [1:0]  cc_pop_level,
  output logic [1:0]       cc_level,
  output logic             cc_push,
  output logic             pc_load,
  output logic [15:0]      pc_vector,
  // watchdog and option pins
  input  wire logic        watchdog_enabled,
  input  wire logic        watchdog_halt_option,
  input  wire logic        stab_long_option,
  output logic             watchdog_reset,
  // clock gating
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_enable,
  output logic             rtc_enable,
  output logic             rc_osc_enable
);
  psmc_state_t       state_q;
  psmc_state_t       state_d;
  logic [4:0]        ctrl_q;
  logic [4:0]        ctrl_nxt;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic              opt_s1_q;
  logic              opt_s2_q;
  logic              wdg_s1_q;
  logic              wdg_s2_q;
  logic              opt_q;
  logic [1:0]        age_q;
  logic              booted_q;
  logic              wake_reset_q;
  logic [1:0]        wake_prio_q;
  logic [15:0]       wake_vec_q;
  logic              stab_start;
  logic              stab_busy;
  logic              stab_done;
  logic [STAB_W-1:0] stab_term;
  logic              div_tick;
  logic              slow_en;
  logic              oscillator_interrupt_enable;
  logic              auto_wakeup_enable;
  logic              wdg_trip;
  logic              halt_wake;
  logic              addr_ok;

  assign slow_en  = ctrl_q[CTRL_SLOW_BIT];
  assign oscillator_interrupt_enable      = ctrl_q[CTRL_OIE_BIT];
  assign auto_wakeup_enable    = ctrl_q[CTRL_AWU_BIT];
  // active halt never trips the watchdog
  assign wdg_trip = watchdog_enabled && !wdg_s2_q && !oscillator_interrupt_enable;
  assign halt_wake = irq_pending && irq_halt_capable;
  assign addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);

  psmc_divider u_div (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .slow_mode_select    (slow_en),
    .slow_divider_select (ctrl_q[CTRL_DIV_LSB +: 2]),
    .tick_q              (div_tick)
  );

  psmc_stab #(
    .STAB_SHORT_CYC (STAB_SHORT_CYC),
    .STAB_LONG_CYC  (STAB_LONG_CYC)
  ) u_stab (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (stab_start),
    .long_sel (opt_q),
    .busy_q   (stab_busy),
    .done_q   (stab_done),
    .term     (stab_term)
  );

  // option pin is synchronised, then frozen once after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_s1_q <= 1'b0;
      opt_s2_q <= 1'b0;
      wdg_s1_q <= 1'b0;
      wdg_s2_q <= 1'b0;
      age_q    <= 2'h0;
      opt_q    <= 1'b0;
    end else begin
      opt_s1_q <= stab_long_option;
      opt_s2_q <= opt_s1_q;
      wdg_s1_q <= watchdog_halt_option;
      wdg_s2_q <= wdg_s1_q;
      if (age_q != 2'h3) begin
        age_q <= age_q + 2'h1;
      end
      if (age_q == 2'h2) begin
        opt_q <= opt_s2_q; // [RULE16]
      end
    end
  end

  // boot delay starts once the option is known; plain and auto wakeup halt exits start it too, active halt exits do not
  assign stab_start = (age_q == 2'h3 && !booted_q) ||
                      (state_q != ST_STAB && state_d == ST_STAB); // [RULE10]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      booted_q <= 1'b0;
    end else if (age_q == 2'h3) begin
      booted_q <= 1'b1;
    end
  end

  // ahb: data phase write, read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_q;
    if (wr_pend_q && wr_addr_q == CTRL_OFS) begin
      ctrl_nxt = hwdata[4:0]; // [RULE2]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_nxt;
    end
  end

  // a write still in its data phase is forwarded to a following read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite && haddr[31:8] == 24'h00_0000) begin
      if (haddr[7:0] == CTRL_OFS) begin
        hrdata <= {27'h000_0000, ctrl_nxt};
      end else if (haddr[7:0] == STATUS_OFS) begin
        hrdata <= {21'h00_0000, cc_level, opt_q, stab_busy,
                   slow_en, state_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end else if (addr_ok) begin
      hrdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (wait_for_interrupt_instr) begin
          state_d = ST_WAIT; // [RULE2]
        end else if (halt_instr && oscillator_interrupt_enable) begin
          state_d = ST_ACT; // [RULE14]
        end else if (halt_instr && wdg_trip) begin
          state_d = ST_RUN; // [RULE13]
        end else if (halt_instr && auto_wakeup_enable) begin
          state_d = ST_AWU; // [RULE15]
        end else if (halt_instr) begin
          state_d = ST_HALT; // [RULE9]
        end
      end
      ST_WAIT: begin
        if (irq_pending) begin
          state_d = ST_RUN; // [RULE7]
        end
      end
      ST_HALT, ST_AWU: begin
        if (halt_wake) begin
          state_d = ST_STAB; // [RULE10]
        end
      end
      ST_ACT: begin
        // oscillator kept running, so an interrupt exit needs no delay
        if (halt_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_STAB;
    end else begin
      state_q <= state_d;
    end
  end

  // wake source remembered across the stabilisation delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_reset_q <= 1'b1;
      wake_prio_q  <= 2'h0;
      wake_vec_q   <= 16'h0000;
    end else if ((state_q == ST_HALT || state_q == ST_AWU) && halt_wake) begin
      wake_reset_q <= 1'b0;
      wake_prio_q  <= irq_priority;
      wake_vec_q   <= irq_vector;
    end
  end

  // interrupt level, vector load and context push
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_level  <= CC_LVL_RESET;
      cc_push   <= 1'b0;
      pc_load   <= 1'b0;
      pc_vector <= 16'h0000;
    end else begin
      cc_push <= 1'b0;
      pc_load <= 1'b0;
      if (state_q == ST_RUN && state_d == ST_WAIT) begin
        cc_level <= CC_LVL_FORCE; // [RULE6]
      end else if (state_q == ST_RUN && state_d != ST_RUN) begin
        cc_level <= CC_LVL_FORCE; // [RULE11]
      end else if ((state_q == ST_WAIT || state_q == ST_ACT) && state_d == ST_RUN) begin
        cc_push   <= 1'b1;
        cc_level  <= irq_priority; // [RULE8]
        pc_load   <= 1'b1;
        pc_vector <= irq_vector; // [RULE7]
      end else if (state_q == ST_STAB && stab_done && wake_reset_q) begin
        pc_load   <= 1'b1;
        pc_vector <= VEC_RESET; // [RULE1]
      end else if (state_q == ST_STAB && stab_done) begin
        cc_push   <= 1'b1;
        cc_level  <= wake_prio_q; // [RULE8]
        pc_load   <= 1'b1;
        pc_vector <= wake_vec_q; // [RULE10]
      end else if (cc_pop) begin
        cc_level <= cc_pop_level; // [RULE8]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= state_q == ST_RUN && !wait_for_interrupt_instr &&
                        halt_instr && wdg_trip; // [RULE13]
    end
  end

  // clock gates follow the next state so they line up with state_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_enable    <= 1'b1;
      rtc_enable    <= 1'b1;
      rc_osc_enable <= 1'b0;
    end else begin
      cpu_clk_en    <= state_d == ST_RUN && div_tick; // [RULE5]
      periph_clk_en <= (state_d == ST_RUN || state_d == ST_WAIT) && div_tick; // [RULE4]
      osc_enable    <= state_d != ST_HALT && state_d != ST_AWU; // [RULE12]
      rtc_enable    <= state_d != ST_HALT && state_d != ST_AWU; // [RULE14]
      rc_osc_enable <= state_d == ST_AWU; // [RULE15]
    end
  end

  // checks
  logic [STAB_W:0] busy_cnt_h;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt_h <= '0;
    end else if (stab_busy) begin
      busy_cnt_h <= busy_cnt_h + (STAB_W+1)'(1);
    end else begin
      busy_cnt_h <= '0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_reset_fetch: assert property ( // [RULE1]
    state_q == ST_STAB && stab_done && wake_reset_q |=>
      state_q == ST_RUN && pc_load && pc_vector == VEC_RESET)
    else $error("reset delay did not end in run with reset vector");
  a_slow_clock: assert property ( // [RULE3]
    state_q == ST_RUN && $past(state_d) == ST_RUN |-> cpu_clk_en == $past(div_tick))
    else $error("cpu clock does not follow divider in run");
  a_wait_cpu_off: assert property ( // [RULE5]
    state_q == ST_WAIT |-> !cpu_clk_en && periph_clk_en == $past(div_tick))
    else $error("wait mode clocks wrong");
  a_wait_level: assert property ( // [RULE6]
    state_q == ST_RUN && wait_for_interrupt_instr |=> state_q == ST_WAIT && cc_level == 2'h2)
    else $error("wait entry did not force level");
  a_wait_wake: assert property ( // [RULE7]
    state_q == ST_WAIT && irq_pending |=>
      state_q == ST_RUN && pc_load && cc_push && pc_vector == $past(irq_vector))
    else $error("wait wake did not load vector");
  a_push_prio: assert property ( // [RULE8]
    $rose(cc_push) |-> cc_level == $past(irq_priority) || cc_level == $past(wake_prio_q))
    else $error("push without routine priority");
  a_halt_select: assert property ( // [RULE9]
    state_q == ST_RUN && !wait_for_interrupt_instr && halt_instr && !oscillator_interrupt_enable && !auto_wakeup_enable &&
      !wdg_trip |=> state_q == ST_HALT && !osc_enable)
    else $error("plain halt not entered");
  a_stab_len: assert property ( // [RULE10]
    $rose(stab_done) |-> busy_cnt_h == {1'b0, stab_term})
    else $error("stabilisation delay length wrong");
  a_halt_level: assert property ( // [RULE11]
    $rose(state_q == ST_HALT || state_q == ST_AWU || state_q == ST_ACT) |-> cc_level == 2'h2)
    else $error("halt entry did not force level");
  a_halt_osc_off: assert property ( // [RULE12]
    state_q == ST_HALT |-> !osc_enable && !cpu_clk_en && !periph_clk_en && !rc_osc_enable)
    else $error("halt leaves clocks on");
  a_wdg_reset: assert property ( // [RULE13]
    state_q == ST_RUN && !wait_for_interrupt_instr && halt_instr && wdg_trip |=>
      watchdog_reset && state_q == ST_RUN)
    else $error("watchdog reset missing on halt");
  a_act_halt: assert property ( // [RULE14]
    state_q == ST_ACT |-> osc_enable && rtc_enable && !cpu_clk_en)
    else $error("active halt oscillator stopped");
  a_awu_halt: assert property ( // [RULE15]
    state_q == ST_AWU |-> rc_osc_enable && !osc_enable)
    else $error("auto wakeup halt clocks wrong");

  c_wait_wake: cover property (state_q == ST_WAIT ##1 state_q == ST_RUN);
  c_halt_exit: cover property (state_q == ST_STAB && stab_done && !wake_reset_q);
  c_slow_wait: cover property (state_q == ST_WAIT && slow_en);
  c_wdg_trip: cover property (watchdog_reset);
endmodule
`default_nettype wire

//--- bench/test_power_saving_mode_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_power_saving_mode_control import psmc_pkg::*; ;
  localparam int NS = 4;
  localparam int NL = 8;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, s;
  logic [1:0]  htrans, irq_priority, cc_pop_level, cc_level, pri;
  logic [2:0]  hsize;
  logic        wait_for_interrupt_instr, halt_instr, irq_pending, irq_halt_capable, cc_pop;
  logic [15:0] irq_vector, pc_vector, vec;
  logic        cc_push, pc_load, watchdog_enabled, watchdog_halt_option, stab_long_option;
  logic        watchdog_reset, cpu_clk_en, periph_clk_en, osc_enable, rtc_enable, rc_osc_enable;
  logic [7:0]  rnd_q;
  logic [3:0]  hcfg [6];
  psmc_state_t hst [6];
  int          n_errors, total_checks, cyc, i, k, c, cc;

  psmc_top #(.STAB_SHORT_CYC(NS), .STAB_LONG_CYC(NL)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .wait_for_interrupt_instr(wait_for_interrupt_instr), .halt_instr(halt_instr),
    .irq_pending(irq_pending), .irq_halt_capable(irq_halt_capable),
    .irq_priority(irq_priority), .irq_vector(irq_vector), .cc_pop(cc_pop),
    .cc_pop_level(cc_pop_level), .cc_level(cc_level), .cc_push(cc_push), .pc_load(pc_load),
    .pc_vector(pc_vector), .watchdog_enabled(watchdog_enabled),
    .watchdog_halt_option(watchdog_halt_option), .stab_long_option(stab_long_option),
    .watchdog_reset(watchdog_reset), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .osc_enable(osc_enable), .rtc_enable(rtc_enable), .rc_osc_enable(rc_osc_enable)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [7:0] lfsr_f(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a hang anywhere counts against the run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask

  task automatic chk_cnt(input int g, input int e);
    chk_word(32'(g), 32'(e));
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    // only the bench timeout ends a stalled transfer
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); end while (hreadyout !== 1'b1);
    q = hrdata;
    chk_bit(hresp, 1'b0);
  endtask

  // count edges until the vector load pulse shows, called just after the cause edge
  task automatic wait_load(output int n);
    n = 0;
    while (pc_load !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
      #1;
    end
  endtask

  task automatic cnt_en(input int n, output int p, output int q);
    p = 0;
    q = 0;
    repeat (n) begin
      @(posedge hclk);
      #1;
      p += (periph_clk_en === 1'b1);
      q += (cpu_clk_en === 1'b1);
    end
  endtask

  task automatic do_reset(input logic opt);
    @(posedge hclk);
    hresetn <= 1'b0;
    stab_long_option <= opt;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    wait_load(k);
    chk_cnt(k, (opt ? NL : NS) + 5);
    chk_word({16'h0, pc_vector}, {16'h0, VEC_RESET});
    chk_word(32'(cc_level), 32'(CC_LVL_RESET));
    ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0, r);
    chk_word(32'(r[5:0]), 32'(ST_RUN));
    chk_bit(r[STAT_OPT_BIT], opt);
    $display("test reset option %0d done", opt);
  endtask

  task automatic pick();
    rnd_q = lfsr_f(rnd_q);
    pri = rnd_q[1:0];
    vec[15:8] = rnd_q;
    rnd_q = lfsr_f(rnd_q);
    vec[7:0] = rnd_q;
  endtask

  initial begin
    {hresetn, hsel, hwrite, wait_for_interrupt_instr, halt_instr, irq_pending} = 6'h00;
    {irq_halt_capable, cc_pop, watchdog_enabled, watchdog_halt_option} = 4'h0;
    {haddr, hwdata} = 64'h0;
    {htrans, irq_priority, cc_pop_level} = 6'h00;
    hsize = 3'h2;
    irq_vector = 16'h0000;
    stab_long_option = 1'b1;
    rnd_q = 8'h0A;
    hcfg = '{4'h0, 4'hA, 4'h4, 4'hC, 4'h2, 4'h3};
    hst = '{ST_HALT, ST_ACT, ST_AWU, ST_ACT, ST_RUN, ST_HALT};
    do_reset(1'b1);
    do_reset(1'b0);
    // register access, a read-only word and unmapped places
    for (i = 0; i < 4; i++) begin
      pick();
      ahb(1'b1, {24'h0, CTRL_OFS}, {vec, vec}, r);
      ahb(1'b0, {24'h0, CTRL_OFS}, 32'h0, r);
      chk_word(r, {vec, vec} & 32'h1F);
    end
    ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0, s);
    ahb(1'b1, {24'h0, STATUS_OFS}, ~s, r);
    ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0, r);
    chk_word(r, s);
    ahb(1'b0, 32'h0000_0100, 32'h0, r);
    chk_word(r, 32'h0);
    // a write above the decoded range must leave the control word alone
    ahb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF, r);
    ahb(1'b0, {24'h0, CTRL_OFS}, 32'h0, r);
    chk_word(r, {vec, vec} & 32'h1F);
    ahb(1'b0, 32'h0000_0008, 32'h0, r);
    chk_word(r, 32'h0);
    $display("test registers done");
    // every divider code, then full rate
    for (i = 0; i < 5; i++) begin
      ahb(1'b1, {24'h0, CTRL_OFS}, (i < 4) ? {29'h0, i[1:0], 1'b1} : 32'h0, r);
      cnt_en(16, c, cc);
      cnt_en(64, c, cc);
      chk_cnt(cc, (i < 4) ? (64 >> (i + 1)) : 64);
      chk_cnt(c, (i < 4) ? (64 >> (i + 1)) : 64);
    end
    $display("test slow done");
    // wait at full rate, then slow-wait
    for (i = 0; i < 2; i++) begin
      ahb(1'b1, {24'h0, CTRL_OFS}, {31'h0, i[0]}, r);
      @(posedge hclk);
      wait_for_interrupt_instr <= 1'b1;
      @(posedge hclk);
      wait_for_interrupt_instr <= 1'b0;
      #1;
      chk_word(32'(cc_level), 32'(CC_LVL_FORCE));
      cnt_en(32, c, cc);
      chk_cnt(cc, 0);
      chk_cnt(c, i ? 16 : 32);
      pick();
      @(posedge hclk);
      irq_pending <= 1'b1;
      irq_priority <= pri;
      irq_vector <= vec;
      @(posedge hclk);
      irq_pending <= 1'b0;
      #1;
      wait_load(k);
      chk_cnt(k, 0);
      chk_word({16'h0, pc_vector}, {16'h0, vec});
      chk_bit(cc_push, 1'b1);
      chk_word(32'(cc_level), 32'(pri));
      @(posedge hclk);
      cc_pop <= 1'b1;
      cc_pop_level <= ~pri;
      @(posedge hclk);
      cc_pop <= 1'b0;
      #1;
      chk_word(32'(cc_level), {30'h0, ~pri});
    end
    $display("test wait done");
    // halt selection table, watchdog cases and wake-up
    for (i = 0; i < 6; i++) begin
      ahb(1'b1, {24'h0, CTRL_OFS}, {27'h0, hcfg[i][2], hcfg[i][3], 3'h0}, r);
      pick();
      // option pin passes a synchroniser, so it settles before the halt
      watchdog_enabled <= hcfg[i][1];
      watchdog_halt_option <= hcfg[i][0];
      repeat (2) @(posedge hclk);
      halt_instr <= 1'b1;
      @(posedge hclk);
      halt_instr <= 1'b0;
      irq_pending <= 1'b1;
      irq_priority <= pri;
      irq_vector <= vec;
      #1;
      chk_bit(watchdog_reset, hst[i] == ST_RUN);
      // a pending source without halt exit capability must not wake
      ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0, r);
      chk_word(32'(r[5:0]), 32'(hst[i]));
      if (hst[i] != ST_RUN) begin
        chk_word(32'(r[STAT_LVL_LSB+:2]), 32'(CC_LVL_FORCE));
        chk_bit(osc_enable, hst[i] == ST_ACT);
        chk_bit(rtc_enable, hst[i] == ST_ACT);
        chk_bit(rc_osc_enable, hst[i] == ST_AWU);
        cnt_en(8, c, cc);
        chk_cnt(c + cc, 0);
        @(posedge hclk);
        irq_halt_capable <= 1'b1;
        @(posedge hclk);
        irq_halt_capable <= 1'b0;
        irq_pending <= 1'b0;
        #1;
        if (hst[i] != ST_ACT) chk_bit(osc_enable, 1'b1);
        wait_load(k);
        chk_cnt(k, (hst[i] == ST_ACT) ? 0 : NS + 1);
        chk_word({16'h0, pc_vector}, {16'h0, vec});
        chk_bit(cc_push, 1'b1);
        chk_word(32'(cc_level), 32'(pri));
      end
      @(posedge hclk);
      irq_pending <= 1'b0;
      watchdog_enabled <= 1'b0;
    end
    $display("test halt done");
    close_out();
  end
endmodule
`default_nettype wire
